// ---- verilog/aale_exec.sv ----
// aale_exec: executes accumulator and auxiliary register loads with cycle accounting
// assumes operand data is valid with START; wait counts come from the memory interface
`timescale 1ns/100ps
`default_nettype none
module aale_exec (
    input wire logic CLK,                                  // cpu clock
    input wire logic RST_N,                                // sync reset, active low
    input wire logic START,                                // one-cycle request pulse
    input wire aale_pkg::aale_op_e OP,                     // load family
    input wire logic [aale_pkg::AALE_DW-1:0] OPERAND,      // memory word or constant
    input wire logic [aale_pkg::AALE_SHIFT_W-1:0] SHIFT,   // coded shift, 0 default
    input wire logic [aale_pkg::AALE_DW-1:0] TEMP_MULT,    // temporary multiplicand reg
    input wire logic SIGN_EXT_MODE,                        // sign extension mode bit
    input wire logic [aale_pkg::AALE_ARP_W-1:0] AUX_SEL,   // target aux register
    input wire logic INDIRECT,                             // indirect addressing form
    input wire logic NEXT_ARP_VALID,                       // next pointer coded
    input wire logic [aale_pkg::AALE_ARP_W-1:0] NEXT_ARP,  // next aux register
    input wire logic [15:0] INSTR_WORD,                    // instruction word, dma in low bits
    input wire logic OPND_EXT,                             // operand in external memory
    input wire logic CODE_EXT,                             // code in external memory
    input wire logic SAME_SINGLE_ACCESS_RAM,                           // operand and code same block
    input wire logic [aale_pkg::AALE_WAIT_W-1:0] DATA_WAIT, // data wait count
    input wire logic [aale_pkg::AALE_WAIT_W-1:0] PROG_WAIT, // program wait count
    input wire logic [aale_pkg::AALE_CNT_W-1:0] REPEAT_N,  // iterations, 0 means single
    output logic BUSY,                                     // executing
    output logic DONE,                                     // one-cycle completion pulse
    output logic [aale_pkg::AALE_AW-1:0] ACC,              // accumulator
    output logic [aale_pkg::AALE_NAR*aale_pkg::AALE_DW-1:0] AUX_REGS, // aux regs packed
    output logic [aale_pkg::AALE_ARP_W-1:0] AUX_REG_POINTER,           // aux register pointer
    output logic [aale_pkg::AALE_DMA_W-1:0] DMA            // direct address low bits
);
    import aale_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // widen a word with or without sign and shift left, zero filling below
    function automatic logic [AALE_AW-1:0] shl_ext(input logic [AALE_DW-1:0] d,
                                                   input logic sx,
                                                   input logic [4:0] sh);
        logic [AALE_AW-1:0] w;
        w = {{AALE_DW{sx & d[AALE_DW-1]}}, d};
        shl_ext = w << sh;
    endfunction : shl_ext

    function automatic logic [AALE_CNT_W-1:0] w16(input logic [AALE_WAIT_W-1:0] w);
        w16 = {{(AALE_CNT_W-AALE_WAIT_W){1'b0}}, w};
    endfunction : w16

    aale_reg_s q_r;
    aale_reg_s d_nxt;
    logic [AALE_CNT_W-1:0] n_eff;
    logic [AALE_CNT_W-1:0] cycles;
    logic [AALE_AW-1:0] acc_new;
    logic [AALE_NAR*AALE_DW-1:0] ar_new;
    logic [AALE_ARP_W-1:0] arp_new;
    logic [AALE_DMA_W-1:0] dma_new;

    // ****************************************************************
    // cycle accounting helpers
    // ****************************************************************
    // wait states of n external data reads, none when the operand is on chip
    function automatic logic [AALE_CNT_W-1:0] data_waits(input logic [AALE_CNT_W-1:0] n,
                                                         input logic ext,
                                                         input logic [AALE_WAIT_W-1:0] dw);
        logic [AALE_CNT_W-1:0] t;
        t = AALE_CNT_W'(n * w16(dw));
        data_waits = ext ? t : '0;
    endfunction : data_waits

    // memory-operand forms: n base cycles, doubled for aux loads
    function automatic logic [AALE_CNT_W-1:0] mem_cycles(input logic [AALE_CNT_W-1:0] n,
                                                         input logic aux,
                                                         input logic opnd_ext,
                                                         input logic code_ext,
                                                         input logic same_blk,
                                                         input logic [AALE_WAIT_W-1:0] dw,
                                                         input logic [AALE_WAIT_W-1:0] pw);
        logic [AALE_CNT_W-1:0] c;
        c = AALE_CNT_W'(n + data_waits(n, opnd_ext, dw));
        if (aux) begin
            // aux register loads spend two cycles per word
            c = AALE_CNT_W'(c + n);
        end
        if (same_blk && !opnd_ext && !code_ext) begin
            // operand and code contend for one single-access block
            c = AALE_CNT_W'(c + AALE_ONE);
        end
        if (code_ext) begin
            // external fetch, one more cycle when both sides are external
            c = AALE_CNT_W'(c + w16(pw) + (opnd_ext ? AALE_ONE : '0));
        end
        mem_cycles = c;
    endfunction : mem_cycles

    // constant forms: base cycles plus program waits per fetched word
    function automatic logic [AALE_CNT_W-1:0] const_cycles(input logic [AALE_CNT_W-1:0] base,
                                                           input logic [AALE_CNT_W-1:0] fetches,
                                                           input logic code_ext,
                                                           input logic [AALE_WAIT_W-1:0] pw);
        logic [AALE_CNT_W-1:0] t;
        t = AALE_CNT_W'(base + fetches * w16(pw));
        const_cycles = code_ext ? t : base;
    endfunction : const_cycles

    // ****************************************************************
    // cycle count
    // ****************************************************************
    // total cycles of the request now on the inputs
    always_comb begin
        n_eff = (REPEAT_N == '0) ? AALE_ONE : REPEAT_N;
        unique case (OP)
            AALE_OP_SHIFT_LK: begin
                // two words fetched
                cycles = const_cycles(AALE_TWO, AALE_TWO, CODE_EXT, PROG_WAIT);
            end
            AALE_OP_LOW_K: begin
                // one-word constant form
                cycles = const_cycles(AALE_ONE, AALE_ONE, CODE_EXT, PROG_WAIT);
            end
            AALE_OP_AUX_K: begin
                // aux constant costs two cycles on chip
                cycles = const_cycles(AALE_TWO, AALE_ONE, CODE_EXT, PROG_WAIT);
            end
            AALE_OP_SHIFT, AALE_OP_SHIFT16, AALE_OP_LOW, AALE_OP_TEMP_MULTIPLICAND_REG, AALE_OP_AUX: begin
                // memory-operand forms: n on chip, n+nd external, each plus n for aux loads
                cycles = mem_cycles(n_eff, OP == AALE_OP_AUX, OPND_EXT, CODE_EXT,
                                    SAME_SINGLE_ACCESS_RAM, DATA_WAIT, PROG_WAIT);
            end
        endcase
    end

    // ****************************************************************
    // result paths
    // ****************************************************************
    // accumulator value for each family; aux loads leave it alone
    always_comb begin
        acc_new = q_r.acc;
        unique case (OP)
            AALE_OP_SHIFT, AALE_OP_SHIFT_LK: begin
                // memory word or long constant with coded shift
                acc_new = shl_ext(OPERAND, SIGN_EXT_MODE, {1'b0, SHIFT});
            end
            AALE_OP_SHIFT16: begin
                // operand lands in the upper half
                acc_new = shl_ext(OPERAND, SIGN_EXT_MODE, AALE_SHIFT16);
            end
            AALE_OP_LOW: begin
                // unsigned word in the lower half
                acc_new = shl_ext(OPERAND, 1'b0, 5'h00);
            end
            AALE_OP_LOW_K: begin
                // short constant, zero above
                acc_new = {{(AALE_AW-AALE_SK_W){1'b0}}, OPERAND[AALE_SK_W-1:0]};
            end
            AALE_OP_TEMP_MULTIPLICAND_REG: begin
                // dynamic shift from the temp register
                acc_new = shl_ext(OPERAND, SIGN_EXT_MODE,
                                  {1'b0, TEMP_MULT[AALE_SHIFT_W-1:0]});
            end
            AALE_OP_AUX, AALE_OP_AUX_K: begin
                // accumulator untouched
                acc_new = q_r.acc;
            end
        endcase
    end

    // aux register file with the selected entry replaced on aux loads
    always_comb begin
        ar_new = q_r.ar;
        if (OP == AALE_OP_AUX || OP == AALE_OP_AUX_K) begin
            // constants and words both land unsigned
            ar_new[AUX_SEL*AALE_DW +: AALE_DW] = OPERAND;
        end
    end

    // pointer follows the coded next register on indirect forms only
    always_comb begin
        arp_new = (INDIRECT && NEXT_ARP_VALID) ? NEXT_ARP : q_r.aux_reg_pointer;
        dma_new = INSTR_WORD[AALE_DMA_W-1:0];
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d_nxt = q_r;
        d_nxt.done = 1'b0;
        unique case (q_r.state)
            AALE_IDLE: begin
                if (START) begin
                    // results land at the accepting edge
                    d_nxt.dma = dma_new;
                    d_nxt.acc = acc_new;
                    d_nxt.ar = ar_new;
                    d_nxt.aux_reg_pointer = arp_new;
                    if (cycles == AALE_ONE) begin
                        d_nxt.done = 1'b1;
                    end else begin
                        d_nxt.state = AALE_BUSY;
                        d_nxt.cnt = AALE_CNT_W'(cycles - AALE_TWO);
                    end
                end
            end
            AALE_BUSY: begin
                if (q_r.cnt == '0) begin
                    d_nxt.state = AALE_IDLE;
                    d_nxt.done = 1'b1;
                end else begin
                    d_nxt.cnt = AALE_CNT_W'(q_r.cnt - AALE_ONE);
                end
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            q_r <= '{state: AALE_IDLE, default: '0};
        end else begin
            q_r <= d_nxt;
        end
    end

    // outputs straight from the state flops
    assign BUSY = (q_r.state == AALE_BUSY);
    assign DONE = q_r.done;
    assign ACC = q_r.acc;
    assign AUX_REGS = q_r.ar;
    assign AUX_REG_POINTER = q_r.aux_reg_pointer;
    assign DMA = q_r.dma;
endmodule : aale_exec
`default_nettype wire

// ---- verilog/aale_pkg.sv ----
// aale_pkg: constants and types shared by the accumulator and auxiliary load execution unit
// assumes a 16-bit data path, a 32-bit accumulator and eight auxiliary registers
package aale_pkg;
    // ****************************************************************
    // widths and fields
    // ****************************************************************
    localparam int AALE_DW = 16;
    localparam int AALE_AW = 32;
    localparam int AALE_DMA_W = 7;
    localparam int AALE_SHIFT_W = 4;
    localparam int AALE_NAR = 8;
    localparam int AALE_ARP_W = 3;
    localparam int AALE_SK_W = 8;
    localparam int AALE_WAIT_W = 8;
    localparam int AALE_CNT_W = 16;
    localparam logic [4:0] AALE_SHIFT16 = 5'h10;
    localparam logic [AALE_SHIFT_W-1:0] AALE_SHIFT_DEF = 4'h0;
    localparam logic [AALE_CNT_W-1:0] AALE_ONE = 16'h0001;
    localparam logic [AALE_CNT_W-1:0] AALE_TWO = 16'h0002;

    // instruction families
    typedef enum logic [2:0] {
        AALE_OP_SHIFT,     // shifted accumulator load, direct/indirect
        AALE_OP_SHIFT16,   // shift-of-16 form
        AALE_OP_SHIFT_LK,  // long constant form
        AALE_OP_LOW,       // low-half load from memory
        AALE_OP_LOW_K,     // low-half load short constant
        AALE_OP_TEMP_MULTIPLICAND_REG,      // shift by temp register
        AALE_OP_AUX,       // aux load from memory
        AALE_OP_AUX_K      // aux load 8- or 16-bit constant
    } aale_op_e;

    typedef enum logic {
        AALE_IDLE,
        AALE_BUSY
    } aale_state_e;

    typedef struct packed {
        aale_state_e state;
        logic [AALE_CNT_W-1:0] cnt;
        logic [AALE_AW-1:0] acc;
        logic [AALE_NAR*AALE_DW-1:0] ar;
        logic [AALE_ARP_W-1:0] aux_reg_pointer;
        logic done;
        logic [AALE_DMA_W-1:0] dma;
    } aale_reg_s;
endpackage : aale_pkg

// ---- test/aale_exec_monitor.sv ----
// aale_exec_monitor: port assertions for the load execution unit
// assumes it is bound to aale_exec and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module aale_exec_monitor
    import aale_pkg::*;
(
    input wire logic CLK, RST_N, START, BUSY, DONE, // clock, reset, handshake
    input wire aale_pkg::aale_op_e OP, // load family
    input wire logic [15:0] OPERAND, INSTR_WORD, REPEAT_N, // operand, word, iterations
    input wire logic [3:0] SHIFT, // coded shift
    input wire logic SIGN_EXT_MODE, INDIRECT, NEXT_ARP_VALID, OPND_EXT, CODE_EXT, SAME_SINGLE_ACCESS_RAM, // modes
    input wire logic [2:0] NEXT_ARP, AUX_REG_POINTER, // pointers
    input wire logic [31:0] ACC, // accumulator
    input wire logic [6:0] DMA // direct address bits
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic go, one;
    // accepted request and single-shot flag
    assign go = START && !BUSY;
    assign one = REPEAT_N < 16'h0002;
    function automatic logic [31:0] sx(input logic [15:0] v, input logic m);
        return m ? {{16{v[15]}}, v} : {16'h0000, v};
    endfunction : sx
    a_shift_value: assert property (go && OP == AALE_OP_SHIFT |=>
        ACC == sx($past(OPERAND), $past(SIGN_EXT_MODE)) << $past(SHIFT)) else $error("shift load");
    a_upper_half: assert property (go && OP == AALE_OP_SHIFT16 |=>
        ACC == {$past(OPERAND), 16'h0000}) else $error("shift16 load");
    a_low_value: assert property (go && OP == AALE_OP_LOW |=>
        ACC == {16'h0000, $past(OPERAND)}) else $error("low load");
    a_short_const: assert property (go && OP == AALE_OP_LOW_K |=>
        ACC == {24'h000000, $past(OPERAND[7:0])}) else $error("short load");
    a_dma_bits: assert property (go |=> DMA == $past(INSTR_WORD[6:0])) else $error("dma");
    a_arp_next: assert property (go && INDIRECT && NEXT_ARP_VALID |=>
        AUX_REG_POINTER == $past(NEXT_ARP)) else $error("pointer");
    a_onchip_one: assert property (go && OP == AALE_OP_SHIFT && one && !OPND_EXT &&
        !CODE_EXT && !SAME_SINGLE_ACCESS_RAM |=> DONE) else $error("one cycle");
    a_single_access_ram_two: assert property (go && OP == AALE_OP_SHIFT && one && !OPND_EXT &&
        !CODE_EXT && SAME_SINGLE_ACCESS_RAM |=> !DONE ##1 DONE) else $error("single_access_ram cycles");
    a_long_two: assert property (go && OP == AALE_OP_SHIFT_LK && !CODE_EXT
        |=> !DONE ##1 DONE) else $error("long cycles");
    a_done_idle: assert property (DONE |-> !BUSY) else $error("done while busy");
    c_repeat: cover property (go && !one);
    c_ext: cover property (go && OPND_EXT);
    c_temp_multiplicand_reg: cover property (go && OP == AALE_OP_TEMP_MULTIPLICAND_REG);
endmodule : aale_exec_monitor
`default_nettype wire

// ---- test/aale_mem_model.sv ----
// aale_mem_model: data and program memory beside the load unit
// assumes combinational reads and fixed wait counts per external access
`timescale 1ns/100ps
`default_nettype none
module aale_mem_model
    import aale_pkg::*;
#(
    parameter int DW = 3, // external data wait states
    parameter int PW = 2 // external program wait states
) (
    input wire logic [6:0] addr, // low address bits
    input wire logic opnd_ext, // operand off chip
    input wire logic code_ext, // code off chip
    output logic [15:0] word, // read word
    output logic [7:0] data_wait, // data wait count
    output logic [7:0] prog_wait // program wait count
);
    // pattern spread over both signs; one wait count per external access
    assign word = 16'h9c35 ^ ({9'h000, addr} * 16'h0b17);
    assign data_wait = opnd_ext ? 8'(DW) : 8'h00;
    assign prog_wait = code_ext ? 8'(PW) : 8'h00;
endmodule : aale_mem_model
`default_nettype wire

// ---- test/aale_exec_test.sv ----
// aale_exec_test: self-checking bench for the load execution unit
// assumes aale_pkg, aale_exec, the memory model and the monitor compiled first
`timescale 1ns/100ps
`default_nettype none
module aale_exec_test;
    import aale_pkg::*;
    localparam int DW = 3;
    localparam int PW = 2;
    logic clk = 0, rst_n = 0, start = 0, sx = 0, ind = 0, nav = 0, oe = 0, ce = 0, ss = 0, imm = 0;
    aale_op_e op = AALE_OP_SHIFT;
    logic [15:0] k = 0, tm = 0, iw = 0, rn = 0, mem_q;
    logic [3:0] sh = 0;
    logic [2:0] sel = 0, narp = 0, aux_reg_pointer, arp_m = 0;
    logic [7:0] dwait, pwait;
    logic busy, done;
    logic [31:0] acc, acc_m = 0;
    logic [127:0] aux;
    logic [15:0] aux_m [8] = '{default: 16'h0000};
    logic [6:0] dma;
    int errors = 0, cmp_count = 0;
    aale_exec uut (.CLK(clk), .RST_N(rst_n), .START(start), .OP(op), .OPERAND(imm ? k : mem_q),
        .SHIFT(sh), .TEMP_MULT(tm), .SIGN_EXT_MODE(sx), .AUX_SEL(sel), .INDIRECT(ind),
        .NEXT_ARP_VALID(nav), .NEXT_ARP(narp), .INSTR_WORD(iw), .OPND_EXT(oe), .CODE_EXT(ce),
        .SAME_SINGLE_ACCESS_RAM(ss), .DATA_WAIT(dwait), .PROG_WAIT(pwait), .REPEAT_N(rn), .BUSY(busy),
        .DONE(done), .ACC(acc), .AUX_REGS(aux), .AUX_REG_POINTER(aux_reg_pointer), .DMA(dma));
    aale_mem_model #(.DW(DW), .PW(PW)) mem (.addr(iw[6:0]), .opnd_ext(oe), .code_ext(ce),
        .word(mem_q), .data_wait(dwait), .prog_wait(pwait));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] ext(input logic [15:0] v);
        return sx ? {{16{v[15]}}, v} : {16'h0000, v};
    endfunction : ext
    // one load: drive at the falling edge, then count cycles up to completion
    task automatic run(input aale_op_e o, input logic e_o, e_c, e_s, input int n);
        int c, exp_c, nn;
        logic [15:0] v;
        logic [31:0] r;
        @(negedge clk);
        r = $urandom;
        {k, tm} = $urandom;
        {iw, sh, sx, sel, narp, nav, ind} = r[28:0];
        op = o; oe = e_o; ce = e_c; ss = e_s; rn = 16'(n); start = 1;
        imm = o inside {AALE_OP_SHIFT_LK, AALE_OP_LOW_K, AALE_OP_AUX_K};
        if (imm) ind = 0;
        #1 v = imm ? k : mem_q;
        nn = (n < 2) ? 1 : n;
        case (o)
            AALE_OP_SHIFT, AALE_OP_SHIFT_LK: acc_m = ext(v) << sh;
            AALE_OP_SHIFT16: acc_m = ext(v) << 16;
            AALE_OP_LOW: acc_m = {16'h0000, v};
            AALE_OP_LOW_K: acc_m = {24'h000000, v[7:0]};
            AALE_OP_TEMP_MULTIPLICAND_REG: acc_m = ext(v) << tm[3:0];
            default: aux_m[sel] = v;
        endcase
        if (ind && nav) arp_m = narp;
        case (o)
            AALE_OP_SHIFT_LK: exp_c = e_c ? 2 + 2 * PW : 2;
            AALE_OP_LOW_K: exp_c = e_c ? 1 + PW : 1;
            AALE_OP_AUX: exp_c = 2 * nn + (e_o ? nn * DW : 0);
            AALE_OP_AUX_K: exp_c = e_c ? 2 + PW : 2;
            default: exp_c = nn + (e_o ? nn * DW : 0) + ((e_s && !e_o && !e_c) ? 1 : 0)
                + (e_c ? PW + int'(e_o) : 0);
        endcase
        @(negedge clk);
        start = 0;
        c = 1;
        while (done !== 1'b1 && c < 200) begin
            check({31'h0, busy}, 32'h1);
            @(negedge clk);
            c++;
        end
        check({31'h0, busy}, 32'h0);
        check(c, exp_c);
        check(acc, acc_m);
        check({16'h0000, aux[16*sel +: 16]}, {16'h0000, aux_m[sel]});
        check({29'h0, aux_reg_pointer}, {29'h0, arp_m});
        check({25'h0, dma}, {25'h0, iw[6:0]});
        $display("test op %0d cycles %0d done", o, c);
    endtask : run
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        forever #2.5 clk = ~clk;
    end
    // hang guard
    initial begin
        #50000;
        errors++;
        end_sim;
    end
    initial begin
        void'($urandom(32'hbd3f));
        repeat (10) @(negedge clk);
        rst_n = 1;
        repeat (4) begin
            for (int i = 0; i < 8; i++) run(aale_op_e'(i), 0, 0, 0, 0);
            run(AALE_OP_SHIFT, 1, 0, 0, 0);
            run(AALE_OP_SHIFT, 0, 0, 1, 0);
            run(AALE_OP_SHIFT, 1, 0, 0, 3);
            run(AALE_OP_TEMP_MULTIPLICAND_REG, 1, 0, 0, 0);
            run(AALE_OP_SHIFT_LK, 0, 1, 0, 0);
            run(AALE_OP_LOW_K, 0, 1, 0, 0);
            run(AALE_OP_AUX, 1, 0, 0, 2);
        end
        end_sim;
    end
endmodule : aale_exec_test
bind aale_exec aale_exec_monitor mon (.*);
`default_nettype wire
